/* dcss_defs.vh */
`ifndef DCSS_DEFS_VH
`define DCSS_DEFS_VH
// Register byte offsets
`define DCSS_ADDR_CMD_CFG 12'h000
`define DCSS_ADDR_IO_CFG 12'h004
`define DCSS_ADDR_JOG 12'h008
`define DCSS_ADDR_SKIP 12'h00C
`define DCSS_ADDR_REF_IN 12'h010
`define DCSS_ADDR_STATUS 12'h014
`define DCSS_ADDR_REF_OUT 12'h018
// Command configuration field positions
`define DCSS_CMD_MODE_LSB 0
`define DCSS_EN_MODE_BIT 4
`define DCSS_RAMP_MODE_LSB 8
`define DCSS_CURVE_BIT 12
`define DCSS_STOP_MODE_LSB 16
// IO configuration field positions
`define DCSS_ADIO_MODE_LSB 0
`define DCSS_ADIO_SRC_LSB 4
`define DCSS_DIO_FUNC_LSB 8
`define DCSS_SIGNED_REF_BIT 12
// Reset values
`define DCSS_CMD_CFG_RST 32'h0000_0000
`define DCSS_IO_CFG_RST 32'h0000_0009
// Timing
`define DCSS_CLK_HZ 125000000
`define DCSS_TICK_MS 1
`define DCSS_TICK_CYC (`DCSS_CLK_HZ / 1000 * `DCSS_TICK_MS)
`define DCSS_FREE_MS 12'h7D0
`define DCSS_READY_MS 12'h3E8
`define DCSS_DC_MS 12'h3E8
// Codes
`define DCSS_ADIO_LOGIC 4'd7
`define DCSS_SRC_USER 3'd4
`define DCSS_DIO_JOG 4'd7
`endif

/* dcss_power_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dcss_power_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // From the sequencer; ov_knob from the testbench
   input wire logic bridge_enable,
   input wire logic ramp_decel,
   input wire logic low_freq_brake,
   input wire logic ov_knob,
   // Feedback
   output logic zero_freq,
   output logic near_zero_speed,
   output logic at_reference,
   output logic min_speed,
   output logic rated_load,
   output logic alarm,
   output logic current_limit,
   output logic bus_over_max,
   output logic bus_near_max,
   output logic analog_signal_lost
);
   logic [7:0] slow_reg;
   logic [5:0] lfsr_reg;
   // Motor takes 41 cycles to run down, so the slowing phases stay visible
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_reg <= 8'h00;
         lfsr_reg <= 6'h01;
      end else begin
         slow_reg <= (ramp_decel || low_freq_brake) ? slow_reg + 8'h01 : 8'h00;
         lfsr_reg <= {lfsr_reg[4:0], lfsr_reg[5] ^ lfsr_reg[4]};
      end
   end
   assign zero_freq = !bridge_enable || (ramp_decel && slow_reg > 8'h28);
   assign near_zero_speed = low_freq_brake && slow_reg > 8'h28;
   // Status lines toggle so a stuck pin output is caught
   assign {at_reference, min_speed, rated_load, current_limit} = lfsr_reg[3:0];
   assign alarm = lfsr_reg[4] & lfsr_reg[5];
   assign bus_near_max = ramp_decel;
   assign bus_over_max = ramp_decel && ov_knob;
   assign analog_signal_lost = 1'b0;
endmodule
`default_nettype wire

/* dcss_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dcss_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched ports
   input wire logic bus_over_max,
   input wire logic near_zero_speed,
   input wire logic fault_reset,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic ramp_decel,
   input wire logic ramp_extend,
   input wire logic curved_profile,
   input wire logic low_freq_brake,
   input wire logic dc_inject,
   input wire logic drive_ready,
   input wire logic bus_overvoltage_trip,
   input wire logic [1:0] analog_pin_kind,
   input wire logic analog_loss_enable,
   input wire logic [2:0] analog_out_source
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_src; analog_pin_kind != 2'h2 |-> analog_out_source == 3'h4; endproperty
   a_src: assert property (p_src) else $error("source not forced");
   property p_loss; analog_loss_enable |-> analog_pin_kind == 2'h0; endproperty
   a_loss: assert property (p_loss) else $error("loss check on non-input");
   property p_dir; run_fwd |-> !run_rev; endproperty
   a_dir: assert property (p_dir) else $error("both directions");
   property p_ov_hold; $fell(bus_overvoltage_trip) |-> fault_reset || $past(fault_reset); endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("trip cleared alone");
   property p_ov_cause; $rose(bus_overvoltage_trip) |-> $past(bus_over_max) || $past(bus_over_max, 2); endproperty
   a_ov_cause: assert property (p_ov_cause) else $error("trip without bus high");
   property p_dc_next; low_freq_brake && near_zero_speed |-> ##[1:4] dc_inject; endproperty
   a_dc_next: assert property (p_dc_next) else $error("no dc after brake");
   property p_dc_busy; dc_inject |-> !drive_ready; endproperty
   a_dc_busy: assert property (p_dc_busy) else $error("ready during dc");
   property p_curve; ramp_decel && ramp_extend |-> !curved_profile; endproperty
   a_curve: assert property (p_curve) else $error("curve in controlled decel");
endmodule
`default_nettype wire

/* dcss_sequencer.v */
// Notes on behaviour
// - Mode 0: held forward and reverse contacts
// - Mode 1: latched start/stop/reverse pulses
// - Pulsed direction change needs intermediate stop
// - Mode 2: run contact plus direction selector
// - Enable mode: plain disable or secure enable
// - Analog pin mode selects input/logic/output
// - Loss detection only for selections 2, 3
// - Output source forced user when pin input
// - Digital pin function selector codes 0-9
// - Jog input substitutes jog frequency
// - Bipolar off clamps negative, on sets direction
// - Skip disabled when skip speed zero
// - Reference inside skip window uses lower edge
// - Ramp mode 0 follows ramp, trips overvoltage
// - Ramp mode 1 extends deceleration time
// - Ramp mode 2 boosts voltage, then extends
// - Ramp mode 3 boosts voltage, imposed ramp
// - Curved profile ignored in modes 1, 2 decel
// - Freewheel stop: bridge off, 2s inhibit, ready
// - Ramp stop: ready one second after stop
// - Ramp then DC injection one second
// - Low-frequency brake, DC one second, inhibit run
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "dcss_defs.vh"
module dcss_sequencer (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Terminals
   input wire command_input_two,
   input wire command_input_three,
   input wire safe_disable_input,
   input wire bidir_digital_pin_in,
   output reg bidir_digital_pin_out,
   output reg bidir_digital_pin_oe,
   input wire analog_digital_pin_logic,
   // Drive feedback
   input wire zero_freq,
   input wire near_zero_speed,
   input wire at_reference,
   input wire min_speed,
   input wire rated_load,
   input wire alarm,
   input wire current_limit,
   input wire bus_over_max,
   input wire bus_near_max,
   input wire analog_signal_lost,
   // Drive commands
   output reg bridge_enable,
   output reg run_fwd,
   output reg run_rev,
   output reg [15:0] speed_ref,
   output reg ramp_decel,
   output reg ramp_extend,
   output reg voltage_boost,
   output reg curved_profile,
   output reg low_freq_brake,
   output reg dc_inject,
   output reg drive_ready,
   output reg bus_overvoltage_trip,
   output reg [1:0] analog_pin_kind,
   output reg analog_loss_enable,
   output reg [2:0] analog_out_source,
   output reg fault_reset
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_RUN = 5'b00010;
   localparam ST_DECEL = 5'b00100;
   localparam ST_DC = 5'b01000;
   localparam ST_WAIT = 5'b10000;

   reg [31:0] cmd_cfg_reg;
   reg [31:0] io_cfg_reg;
   reg [15:0] jog_reg;
   reg [31:0] skip_reg;
   reg [15:0] ref_in_reg;
   reg [1:0] cmd_mode_reg;
   reg en_mode_reg;
   reg [4:0] state_reg;
   reg [16:0] tick_cnt_reg;
   reg [11:0] ms_cnt_reg;
   reg [11:0] ms_target_reg;
   reg fwd_latch_reg;
   reg rev_latch_reg;
   reg inhibit_reg;
   reg tick;
   reg run_req;
   reg dir_rev;
   reg enabled;
   reg jog_sel;
   reg ref_rev;
   reg [15:0] ref_mag;
   reg [1:0] ramp_mode;
   reg [1:0] stop_mode;
   reg [3:0] adio_mode;
   reg [3:0] dio_func;
   reg [15:0] skip_lo;
   reg [15:0] skip_hi;

   function [15:0] sat_sub;
      input [15:0] a;
      input [15:0] b;
      begin
         sat_sub = (a > b) ? a - b : 16'h0000;
      end
   endfunction
   function [15:0] sat_add;
      input [15:0] a;
      input [15:0] b;
      begin
         sat_add = (({1'b0, a} + {1'b0, b}) > 17'h0_FFFF) ? 16'hFFFF : a + b;
      end
   endfunction
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   always @* begin
      ramp_mode = cmd_cfg_reg[`DCSS_RAMP_MODE_LSB +: 2];
      stop_mode = cmd_cfg_reg[`DCSS_STOP_MODE_LSB +: 2];
      adio_mode = io_cfg_reg[`DCSS_ADIO_MODE_LSB +: 4];
      dio_func = io_cfg_reg[`DCSS_DIO_FUNC_LSB +: 4];
      enabled = en_mode_reg ? safe_disable_input : ~safe_disable_input;
      jog_sel = (dio_func == `DCSS_DIO_JOG) && bidir_digital_pin_in;
      run_req = 1'b0;
      dir_rev = 1'b0;
      case (cmd_mode_reg)
         2'd0: begin
            run_req = command_input_two ^ command_input_three;
            dir_rev = command_input_three;
         end
         2'd1: begin
            run_req = fwd_latch_reg | rev_latch_reg;
            dir_rev = rev_latch_reg;
         end
         2'd2: begin
            run_req = command_input_two;
            dir_rev = command_input_three;
         end
         default: run_req = 1'b0;
      endcase
      skip_lo = sat_sub(skip_reg[15:0], skip_reg[31:16]);
      skip_hi = sat_add(skip_reg[15:0], skip_reg[31:16]);
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_mode_reg <= 2'd0;
         en_mode_reg <= 1'b0;
      end else if (!bridge_enable) begin
         cmd_mode_reg <= cmd_cfg_reg[`DCSS_CMD_MODE_LSB +: 2];
         en_mode_reg <= cmd_cfg_reg[`DCSS_EN_MODE_BIT];
      end
   end

   // APB slave, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_cfg_reg <= `DCSS_CMD_CFG_RST;
         io_cfg_reg <= `DCSS_IO_CFG_RST;
         jog_reg <= 16'h0000;
         skip_reg <= 32'h0000_0000;
         ref_in_reg <= 16'h0000;
      end else if (psel && penable && pwrite) begin
         case (paddr)
            `DCSS_ADDR_CMD_CFG: cmd_cfg_reg <= pwdata & 32'h0003_1313;
            `DCSS_ADDR_IO_CFG: begin
               io_cfg_reg <= pwdata & 32'h0000_1F7F;
               if (pwdata[3:0] <= `DCSS_ADIO_LOGIC || pwdata[6:4] > `DCSS_SRC_USER)
                  io_cfg_reg[`DCSS_ADIO_SRC_LSB +: 3] <= `DCSS_SRC_USER;
               if (pwdata[3:0] > 4'd10)
                  io_cfg_reg[3:0] <= io_cfg_reg[3:0];
               if (pwdata[11:8] > 4'd9)
                  io_cfg_reg[11:8] <= io_cfg_reg[11:8];
            end
            `DCSS_ADDR_JOG: jog_reg <= pwdata[15:0];
            `DCSS_ADDR_SKIP: skip_reg <= pwdata;
            `DCSS_ADDR_REF_IN: ref_in_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   always @* begin
      case (paddr)
         `DCSS_ADDR_CMD_CFG: prdata = cmd_cfg_reg;
         `DCSS_ADDR_IO_CFG: prdata = io_cfg_reg;
         `DCSS_ADDR_JOG: prdata = {16'h0000, jog_reg};
         `DCSS_ADDR_SKIP: prdata = skip_reg;
         `DCSS_ADDR_REF_IN: prdata = {16'h0000, ref_in_reg};
         `DCSS_ADDR_STATUS: prdata = {19'h0, bus_overvoltage_trip, inhibit_reg,
            drive_ready, dc_inject, low_freq_brake, run_rev, run_fwd,
            bridge_enable, state_reg};
         `DCSS_ADDR_REF_OUT: prdata = {16'h0000, speed_ref};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // Pulse latches; the stop input wins over start pulses
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_latch_reg <= 1'b0;
         rev_latch_reg <= 1'b0;
      end else if (cmd_mode_reg != 2'd1 || command_input_three || !enabled) begin
         fwd_latch_reg <= 1'b0;
         rev_latch_reg <= 1'b0;
      end else begin
         if (command_input_two && !rev_latch_reg)
            fwd_latch_reg <= 1'b1;
         if (bidir_digital_pin_in && dio_func != `DCSS_DIO_JOG && !fwd_latch_reg)
            rev_latch_reg <= 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 17'd0;
         tick <= 1'b0;
      end else if (tick_cnt_reg == `DCSS_TICK_CYC - 1) begin
         tick_cnt_reg <= 17'd0;
         tick <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 17'd1;
         tick <= 1'b0;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         ms_cnt_reg <= 12'd0;
         ms_target_reg <= 12'd0;
         inhibit_reg <= 1'b0;
         bus_overvoltage_trip <= 1'b0;
      end else begin
         if (bus_over_max && bridge_enable && (ramp_mode == 2'd0 || ramp_mode == 2'd3))
            bus_overvoltage_trip <= 1'b1;
         else if (fault_reset)
            bus_overvoltage_trip <= 1'b0;
         if (tick && ms_cnt_reg != ms_target_reg)
            ms_cnt_reg <= ms_cnt_reg + 12'd1;
         case (state_reg)
            ST_IDLE: begin
               inhibit_reg <= 1'b0;
               if (run_req && enabled && !bus_overvoltage_trip)
                  state_reg <= ST_RUN;
            end
            ST_RUN: begin
               if (!run_req || !enabled || bus_overvoltage_trip) begin
                  ms_cnt_reg <= 12'd0;
                  if (stop_mode == 2'd0 || !enabled || bus_overvoltage_trip) begin
                     ms_target_reg <= `DCSS_FREE_MS;
                     inhibit_reg <= 1'b1;
                     state_reg <= ST_WAIT;
                  end else begin
                     inhibit_reg <= (stop_mode == 2'd3);
                     state_reg <= ST_DECEL;
                  end
               end
            end
            ST_DECEL: begin
               if (stop_mode == 2'd1 && zero_freq) begin
                  ms_cnt_reg <= 12'd0;
                  ms_target_reg <= `DCSS_READY_MS;
                  state_reg <= ST_WAIT;
               end else if ((stop_mode == 2'd2 && zero_freq) ||
                            (stop_mode == 2'd3 && near_zero_speed)) begin
                  ms_cnt_reg <= 12'd0;
                  ms_target_reg <= `DCSS_DC_MS;
                  state_reg <= ST_DC;
               end else if (stop_mode != 2'd3 && run_req && enabled) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_DC: begin
               if (ms_cnt_reg == ms_target_reg)
                  state_reg <= ST_IDLE;
            end
            ST_WAIT: begin
               if (ms_cnt_reg == ms_target_reg)
                  state_reg <= ST_IDLE;
               else if (!inhibit_reg && run_req && enabled)
                  state_reg <= ST_RUN;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_enable <= 1'b0;
         run_fwd <= 1'b0;
         run_rev <= 1'b0;
         speed_ref <= 16'h0000;
         ramp_decel <= 1'b0;
         ramp_extend <= 1'b0;
         voltage_boost <= 1'b0;
         curved_profile <= 1'b0;
         low_freq_brake <= 1'b0;
         dc_inject <= 1'b0;
         drive_ready <= 1'b0;
         analog_pin_kind <= 2'd0;
         analog_loss_enable <= 1'b0;
         analog_out_source <= `DCSS_SRC_USER;
         bidir_digital_pin_out <= 1'b0;
         bidir_digital_pin_oe <= 1'b0;
         fault_reset <= 1'b0;
         ref_rev <= 1'b0;
         ref_mag <= 16'h0000;
      end else begin
         if (jog_sel) begin
            ref_mag <= jog_reg;
            ref_rev <= 1'b0;
         end else if (ref_in_reg[15]) begin
            ref_mag <= io_cfg_reg[`DCSS_SIGNED_REF_BIT] ? (16'h0000 - ref_in_reg)
               : 16'h0000;
            ref_rev <= io_cfg_reg[`DCSS_SIGNED_REF_BIT];
         end else begin
            ref_mag <= ref_in_reg;
            ref_rev <= 1'b0;
         end
         if (skip_reg[15:0] != 16'h0000 && ref_mag >= skip_lo && ref_mag <= skip_hi)
            speed_ref <= skip_lo;
         else
            speed_ref <= ref_mag;
         bridge_enable <= state_reg[1] | state_reg[2] | state_reg[3];
         run_fwd <= state_reg[1] & ~(dir_rev ^ ref_rev);
         run_rev <= state_reg[1] & (dir_rev ^ ref_rev);
         ramp_decel <= state_reg[2] & (stop_mode != 2'd3);
         ramp_extend <= bus_near_max & (ramp_mode == 2'd1 || ramp_mode == 2'd2);
         voltage_boost <= state_reg[2] & (ramp_mode == 2'd2 || ramp_mode == 2'd3);
         curved_profile <= cmd_cfg_reg[`DCSS_CURVE_BIT] &
            ~(state_reg[2] & (ramp_mode == 2'd1 || ramp_mode == 2'd2));
         low_freq_brake <= state_reg[2] & (stop_mode == 2'd3);
         dc_inject <= state_reg[3];
         drive_ready <= state_reg[0];
         analog_pin_kind <= (adio_mode < `DCSS_ADIO_LOGIC) ? 2'd0 :
            (adio_mode == `DCSS_ADIO_LOGIC) ? 2'd1 : 2'd2;
         analog_loss_enable <= (adio_mode == 4'd2) || (adio_mode == 4'd3);
         analog_out_source <= io_cfg_reg[`DCSS_ADIO_SRC_LSB +: 3];
         bidir_digital_pin_oe <= (dio_func <= 4'd6) && (cmd_mode_reg != 2'd1);
         case (dio_func)
            4'd0: bidir_digital_pin_out <= zero_freq;
            4'd1: bidir_digital_pin_out <= at_reference;
            4'd2: bidir_digital_pin_out <= min_speed;
            4'd3: bidir_digital_pin_out <= rated_load;
            4'd4: bidir_digital_pin_out <= bridge_enable;
            4'd5: bidir_digital_pin_out <= alarm;
            4'd6: bidir_digital_pin_out <= current_limit;
            default: bidir_digital_pin_out <= 1'b0;
         endcase
         fault_reset <= (dio_func == 4'd8) & bidir_digital_pin_in;
      end
   end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dcss_defs.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, r, rng = 32'h0000_0015;
   logic command_input_two = 1'b0, command_input_three = 1'b0, safe_disable_input = 1'b0;
   logic pin_drv = 1'b0, ov_knob = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, bidir_digital_pin_in, bidir_digital_pin_out, bidir_digital_pin_oe;
   wire zero_freq, near_zero_speed, at_reference, min_speed, rated_load, alarm, current_limit;
   wire bus_over_max, bus_near_max, analog_signal_lost, bridge_enable, run_fwd, run_rev;
   wire ramp_decel, ramp_extend, voltage_boost, curved_profile, low_freq_brake, dc_inject;
   wire drive_ready, bus_overvoltage_trip, analog_loss_enable, fault_reset;
   wire [1:0] analog_pin_kind;
   wire [2:0] analog_out_source;
   logic [31:0] exp_q[$];
   logic [6:0] fb_d;
   int num_errors = 0, n_tests = 0;
   // Shared pin: the sequencer wins while it drives
   assign bidir_digital_pin_in = bidir_digital_pin_oe ? bidir_digital_pin_out : pin_drv;
   dcss_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .command_input_two, .command_input_three, .safe_disable_input,
      .bidir_digital_pin_in, .bidir_digital_pin_out, .bidir_digital_pin_oe,
      .analog_digital_pin_logic(1'b0), .zero_freq, .near_zero_speed, .at_reference,
      .min_speed, .rated_load, .alarm, .current_limit, .bus_over_max, .bus_near_max,
      .analog_signal_lost, .bridge_enable, .run_fwd, .run_rev, .speed_ref(), .ramp_decel,
      .ramp_extend, .voltage_boost, .curved_profile, .low_freq_brake, .dc_inject, .drive_ready,
      .bus_overvoltage_trip, .analog_pin_kind, .analog_loss_enable, .analog_out_source,
      .fault_reset);
   dcss_power_model model_u (.pclk, .presetn, .bridge_enable, .ramp_decel, .low_freq_brake,
      .ov_knob, .zero_freq, .near_zero_speed, .at_reference, .min_speed, .rated_load, .alarm,
      .current_limit, .bus_over_max, .bus_near_max, .analog_signal_lost);
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      fb_d <= {current_limit, alarm, bridge_enable, rated_load, min_speed, at_reference, zero_freq};
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         `CHK("prdata", exp_q[0], prdata)
         void'(exp_q.pop_front());
      end
   end
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [31:0] cfg(input int cm, en, rm, cv, sm);
      return 32'(cm | en << 4 | rm << 8 | cv << 12 | sm << 16);
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic rst();
      @(posedge pclk);
      presetn <= 1'b0;
      {ov_knob, pin_drv, safe_disable_input, command_input_three, command_input_two} <= 5'h00;
      wt(8);
      presetn <= 1'b1;
      wt(2);
   endtask
   // Contacts and enable line, then settle and sample off the edge
   task automatic hold(input logic [2:0] v, input int n);
      @(posedge pclk);
      {safe_disable_input, command_input_three, command_input_two} <= v;
      wt(n);
      #1;
   endtask
   task automatic pls(input logic [2:0] v);
      hold(3'h0, 1);
      @(posedge pclk);
      {pin_drv, command_input_three, command_input_two} <= v;
      wt(3);
      {pin_drv, command_input_three, command_input_two} <= 3'h0;
      wt(4);
      #1;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      wt(12000);
      num_errors++;
      stop_test();
   end
   initial begin
      rst();
      rd(`DCSS_ADDR_CMD_CFG, `DCSS_CMD_CFG_RST);
      rd(`DCSS_ADDR_IO_CFG, `DCSS_IO_CFG_RST);
      apb(1'b1, 12'h020, 32'hFFFF_FFFF);
      rd(12'h020, 32'h0000_0000);
      // Mode 11 is out of range and must leave the pin as mode 10 left it
      for (int m = 0; m < 12; m++) begin
         apb(1'b1, `DCSS_ADDR_IO_CFG, 32'h0000_0920 | m);
         wt(2);
         #1;
         `CHK("kind", m > 7 ? 2'h2 : m == 7 ? 2'h1 : 2'h0, analog_pin_kind)
         `CHK("loss", m == 2 || m == 3, analog_loss_enable)
         `CHK("source", m > 7 ? 3'h2 : 3'h4, analog_out_source)
      end
      for (int f = 0; f < 9; f++) begin
         pin_drv <= 1'b1;
         apb(1'b1, `DCSS_ADDR_IO_CFG, f << 8);
         wt(2);
         #1;
         `CHK("pin_oe", f < 7, bidir_digital_pin_oe)
         if (f < 7) `CHK("pin_out", fb_d[f], bidir_digital_pin_out)
         if (f == 8) `CHK("fault_reset", 1'b1, fault_reset)
      end
      apb(1'b1, `DCSS_ADDR_JOG, 32'h0000_0123);
      apb(1'b1, `DCSS_ADDR_SKIP, 32'h0400_2000);
      pin_drv <= 1'b0;
      for (int i = 0; i < 11; i++) begin
         r = i == 0 ? 32'h0000_1C01 : i == 1 ? 32'h0000_23FF : 32'h0000_2401;
         if (i > 2) r = xs() & 32'h0000_3FFF;
         apb(1'b1, `DCSS_ADDR_REF_IN, r);
         wt(2);
         rd(`DCSS_ADDR_REF_OUT, r > 32'h0000_1BFF && r < 32'h0000_2401 ? 32'h0000_1C00 : r);
      end
      apb(1'b1, `DCSS_ADDR_SKIP, 32'h0400_0000);
      apb(1'b1, `DCSS_ADDR_REF_IN, 32'h0000_0100);
      wt(2);
      rd(`DCSS_ADDR_REF_OUT, 32'h0000_0100);
      apb(1'b1, `DCSS_ADDR_REF_IN, 32'h0000_FFF0);
      wt(2);
      rd(`DCSS_ADDR_REF_OUT, 32'h0000_0000);
      apb(1'b1, `DCSS_ADDR_IO_CFG, 32'h0000_0700);
      pin_drv <= 1'b1;
      wt(3);
      rd(`DCSS_ADDR_REF_OUT, 32'h0000_0123);
      pin_drv <= 1'b0;
      apb(1'b1, `DCSS_ADDR_IO_CFG, 32'h0000_0900);
      // Settings are changed only with the drive idle
      apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(0, 0, 0, 0, 1));
      hold(3'h1, 5);
      `CHK("run_fwd", 1'b1, run_fwd)
      hold(3'h3, 5);
      `CHK("decel", 1'b1, ramp_decel)
      hold(3'h2, 60);
      `CHK("run_rev", 1'b1, run_rev)
      hold(3'h0, 60);
      apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(2, 0, 0, 0, 1));
      hold(3'h1, 5);
      `CHK("run_fwd", 1'b1, run_fwd)
      hold(3'h0, 60);
      hold(3'h3, 5);
      `CHK("run_rev", 1'b1, run_rev)
      hold(3'h0, 60);
      apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(1, 0, 0, 0, 1));
      pls(3'h1);
      `CHK("run_fwd", 1'b1, run_fwd)
      pls(3'h4);
      `CHK("run_rev", 1'b0, run_rev)
      pls(3'h2);
      `CHK("decel", 1'b1, ramp_decel)
      hold(3'h0, 60);
      pls(3'h4);
      `CHK("run_rev", 1'b1, run_rev)
      pls(3'h2);
      hold(3'h4, 60);
      apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(0, 1, 0, 0, 1));
      hold(3'h5, 5);
      `CHK("run_fwd", 1'b1, run_fwd)
      hold(3'h1, 5);
      `CHK("bridge", 1'b0, bridge_enable)
      hold(3'h0, 60);
      apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(0, 0, 0, 0, 1));
      hold(3'h5, 5);
      `CHK("bridge", 1'b0, bridge_enable)
      hold(3'h0, 60);
      // The freewheel stop above inhibits runs for seconds
      rst();
      for (int m = 3; m >= 0; m--) begin
         @(posedge pclk);
         ov_knob <= m == 0;
         apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(0, 0, m, 1, 1));
         hold(3'h1, 6);
         hold(3'h0, 12);
         if (m != 2) `CHK("extend", m == 1, ramp_extend)
         `CHK("boost", m > 1, voltage_boost)
         `CHK("curve", m == 0 || m == 3, curved_profile)
         wt(60);
      end
      `CHK("ov_trip", 1'b1, bus_overvoltage_trip)
      apb(1'b1, `DCSS_ADDR_IO_CFG, 32'h0000_0800);
      pin_drv <= 1'b1;
      wt(4);
      #1;
      `CHK("ov_trip", 1'b0, bus_overvoltage_trip)
      // A fresh reset per stop mode; mode 1 is skipped here: the real waits last seconds
      for (int s = 0; s < 4; s++) begin
         if (s == 1) continue;
         rst();
         apb(1'b1, `DCSS_ADDR_CMD_CFG, cfg(0, 0, 0, 0, s));
         `CHK("ready", 1'b1, drive_ready)
         hold(3'h1, 6);
         hold(3'h0, 4);
         if (s == 0) `CHK("bridge", 1'b0, bridge_enable)
         if (s == 3) `CHK("lf_brake", 1'b1, low_freq_brake)
         hold(3'h0, 60);
         if (s != 0) `CHK("dc", 1'b1, dc_inject)
         hold(3'h1, 6);
         if (s != 2) `CHK("run_fwd", 1'b0, run_fwd)
         `CHK("ready", 1'b0, drive_ready)
      end
      stop_test();
   end
endmodule
bind dcss_sequencer dcss_props u_props (.pclk, .presetn, .bus_over_max, .near_zero_speed,
   .fault_reset, .run_fwd, .run_rev, .ramp_decel, .ramp_extend, .curved_profile,
   .low_freq_brake, .dc_inject, .drive_ready, .bus_overvoltage_trip, .analog_pin_kind,
   .analog_loss_enable, .analog_out_source);
`default_nettype wire
